/* core/prq_pkg.sv */
// constants and register map for the pending request priority block
package prq_pkg;
   // register indexes; byte address is four times the index
   localparam logic [11:0] IDX_G0_PEND   = 12'hFC0;
   localparam logic [11:0] IDX_G0_EN_HI  = 12'hFC1;
   localparam logic [11:0] IDX_G0_EN_LO  = 12'hFC2;
   localparam logic [11:0] IDX_PC_PEND   = 12'hFC6;
   localparam logic [11:0] IDX_CTRL      = 12'hFC7;
   localparam logic [11:0] IDX_INT_STAT  = 12'hFC8;
   localparam logic [11:0] IDX_INT_MASK  = 12'hFC9;
   localparam logic [11:0] IDX_VEC_STAT  = 12'hFCA;

   localparam int          ADR_W         = 16;
   localparam int          ADR_LSB       = 2;
   localparam int          PC_W          = 4;
   localparam int          G0_W          = 8;
   localparam int          SRC_N         = 12;
   localparam int          PC_BASE       = 8;
   localparam int          EV_W          = 3;

   // field positions
   localparam int          CTRL_GIE      = 0;
   localparam int          EV_PC_REQ     = 0;
   localparam int          EV_G0_REQ     = 1;
   localparam int          EV_POLL_PEND  = 2;

   // reset values and level codes
   localparam logic [7:0]  RST_BYTE      = 8'h00;
   localparam logic [3:0]  RST_PC_PEND   = 4'h0;
   localparam logic [2:0]  RST_EV        = 3'h0;
   localparam logic [1:0]  LVL_OFF       = 2'h0;
   localparam logic [1:0]  LVL_PORT_C    = 2'h1;
endpackage

/* core/prq_sync.sv */
// two-stage synchroniser for the port c request pins
`timescale 1ns/1ps
module prq_sync #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } prq_sync_st_t;

   prq_sync_st_t st_q;
   prq_sync_st_t st_d;

   always_comb begin
      st_d    = st_q;
      st_d.s1 = async_in;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_out = st_q.s2;
endmodule // prq_sync

/* core/prq_ctrl.sv */
// pending request capture, priority selection and wishbone registers
// Functional notes
// - a presented request sets its matching pending bit to one.
// - with global enable on, pending enabled requests go to the core.
// - port c pins 0 to 3 own pending bits 0 to 3; one is pending.
// - enable pair 00 off, 01 level 1, 10 level 2, 11 level 3.
// - each group zero bit takes its level from its own enable bits.
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module prq_ctrl (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [15:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [3:0]  port_c_pin_request,
   input  wire logic [7:0]  request_group_zero,
   input  wire logic        irq_ack,
   output logic             irq_req,
   output logic      [1:0]  irq_level,
   output logic      [3:0]  irq_vec,
   output logic             irq_o
);
   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
      logic [3:0]  pin_prev;
      logic [3:0]  pc_pend;
      logic [7:0]  g0_pend;
      logic [7:0]  en_hi;
      logic [7:0]  en_lo;
      logic        gie;
      logic [2:0]  ev_stat;
      logic [2:0]  ev_mask;
      logic        req;
      logic [1:0]  lvl;
      logic [3:0]  vec;
   } prq_st_t;

   prq_st_t     st_q;
   prq_st_t     st_d;
   logic [3:0]  pin_sync;
   logic [3:0]  pin_rise;
   logic [11:0] idx;
   logic        bus_req;
   logic        wr_now;
   logic        rd_now;
   logic [1:0]  best_lvl;
   logic [3:0]  best_vec;
   logic        found;

   function automatic logic [1:0] prq_level(input logic hi, input logic lo);
      prq_level = {hi, lo};
   endfunction

   function automatic logic [7:0] prq_read(input prq_st_t s,
                                           input logic [11:0] a);
      case (a)
         prq_pkg::IDX_G0_PEND:  prq_read = s.g0_pend;
         prq_pkg::IDX_G0_EN_HI: prq_read = s.en_hi;
         prq_pkg::IDX_G0_EN_LO: prq_read = s.en_lo;
         prq_pkg::IDX_PC_PEND:  prq_read = {4'h0, s.pc_pend};
         prq_pkg::IDX_CTRL:     prq_read = {7'h00, s.gie};
         prq_pkg::IDX_INT_STAT: prq_read = {5'h00, s.ev_stat};
         prq_pkg::IDX_INT_MASK: prq_read = {5'h00, s.ev_mask};
         prq_pkg::IDX_VEC_STAT: prq_read = {s.req, s.lvl, 1'b0, s.vec};
         default:               prq_read = prq_pkg::RST_BYTE;
      endcase
   endfunction

   prq_sync #(
      .W        (prq_pkg::PC_W)
   ) u_pin_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in (port_c_pin_request),
      .sync_out (pin_sync)
   );

   assign pin_rise = pin_sync & ~st_q.pin_prev;
   assign idx      = wb_adr_i[prq_pkg::ADR_LSB +: 12];
   assign bus_req  = wb_cyc_i & wb_stb_i;
   assign wr_now   = bus_req & st_q.ack & wb_we_i & wb_sel_i[0];
   assign rd_now   = bus_req & st_q.ack & ~wb_we_i;

   // highest level first, lowest source index on a tie
   always_comb begin
      best_lvl = prq_pkg::LVL_OFF;
      best_vec = 4'h0;
      found    = 1'b0;
      for (int i = 0; i < prq_pkg::G0_W; i++) begin
         if (st_q.g0_pend[i] &&
             prq_level(st_q.en_hi[i], st_q.en_lo[i]) > best_lvl) begin
            best_lvl = prq_level(st_q.en_hi[i], st_q.en_lo[i]);
            best_vec = 4'(i);
            found    = 1'b1;
         end
      end
      for (int j = 0; j < prq_pkg::PC_W; j++) begin
         if (st_q.pc_pend[j] && prq_pkg::LVL_PORT_C > best_lvl) begin
            best_lvl = prq_pkg::LVL_PORT_C;
            best_vec = 4'(prq_pkg::PC_BASE + j);
            found    = 1'b1;
         end
      end
   end

   always_comb begin
      st_d          = st_q;
      st_d.pin_prev = pin_sync;
      // answer one cycle after the request, drop the cycle after
      st_d.ack      = bus_req & ~st_q.ack;
      st_d.dat      = {24'h000000, prq_read(st_q, idx)};
      // software writes first, so hardware sets below win
      if (wr_now) begin
         case (idx)
            prq_pkg::IDX_G0_PEND:  st_d.g0_pend = st_q.g0_pend &
                                                  wb_dat_i[7:0];
            prq_pkg::IDX_G0_EN_HI: st_d.en_hi   = wb_dat_i[7:0];
            prq_pkg::IDX_G0_EN_LO: st_d.en_lo   = wb_dat_i[7:0];
            prq_pkg::IDX_PC_PEND:  st_d.pc_pend = st_q.pc_pend &
                                                  wb_dat_i[3:0];
            prq_pkg::IDX_CTRL:     st_d.gie     = wb_dat_i[prq_pkg::CTRL_GIE];
            prq_pkg::IDX_INT_MASK: st_d.ev_mask = wb_dat_i[2:0];
            default: ;
         endcase
      end
      // clear only the bits the read returned, so a late set survives
      if (rd_now && idx == prq_pkg::IDX_INT_STAT) begin
         st_d.ev_stat = st_q.ev_stat & ~st_q.dat[2:0];
      end
      // the core taking a vector clears that source
      if (irq_ack && st_q.req) begin
         if (st_q.vec < 4'(prq_pkg::PC_BASE)) begin
            st_d.g0_pend[st_q.vec[2:0]] = 1'b0;
         end else begin
            st_d.pc_pend[st_q.vec[1:0]] = 1'b0;
         end
      end
      st_d.pc_pend = st_d.pc_pend | pin_rise;
      st_d.g0_pend = st_d.g0_pend | request_group_zero;
      if (|pin_rise) begin
         st_d.ev_stat[prq_pkg::EV_PC_REQ] = 1'b1;
      end
      if (|request_group_zero) begin
         st_d.ev_stat[prq_pkg::EV_G0_REQ] = 1'b1;
      end
      if (!st_q.gie && (|st_q.pc_pend || |st_q.g0_pend)) begin
         st_d.ev_stat[prq_pkg::EV_POLL_PEND] = 1'b1;
      end
      st_d.req = st_q.gie & found;
      st_d.lvl = found ? best_lvl : prq_pkg::LVL_OFF;
      st_d.vec = best_vec;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q         <= '0;
         st_q.pc_pend <= prq_pkg::RST_PC_PEND;
         st_q.g0_pend <= prq_pkg::RST_BYTE;
         st_q.en_hi   <= prq_pkg::RST_BYTE;
         st_q.en_lo   <= prq_pkg::RST_BYTE;
         st_q.ev_stat <= prq_pkg::RST_EV;
         st_q.ev_mask <= prq_pkg::RST_EV;
      end else begin
         st_q <= st_d;
      end
   end

   assign wb_ack_o  = st_q.ack;
   assign wb_dat_o  = st_q.dat;
   assign irq_req   = st_q.req;
   assign irq_level = st_q.lvl;
   assign irq_vec   = st_q.vec;
   assign irq_o     = |(st_q.ev_stat & st_q.ev_mask);

   chk_pin_sets_pend: assert property (
      @(posedge clk) disable iff (sys_rst)
      |pin_rise |=> ((st_q.pc_pend & $past(pin_rise)) == $past(pin_rise)))
      else $error("port c edge did not set its pending bit");

   chk_g0_sets_pend: assert property (
      @(posedge clk) disable iff (sys_rst)
      |request_group_zero |=>
         ((st_q.g0_pend & $past(request_group_zero)) ==
          $past(request_group_zero)))
      else $error("group zero request was lost");

   chk_vec_needs_gie: assert property (
      @(posedge clk) disable iff (sys_rst)
      irq_req |-> $past(st_q.gie))
      else $error("vectored request without global enable");

   chk_vec_follows_pend: assert property (
      @(posedge clk) disable iff (sys_rst)
      st_q.gie && (|st_q.pc_pend) |=> irq_req)
      else $error("pending port c request not forwarded");

   chk_level_decode: assert property (
      @(posedge clk) disable iff (sys_rst)
      irq_req && irq_vec < 4'h8 |->
         irq_level == {1'($past(st_q.en_hi) >> irq_vec[2:0]),
                       1'($past(st_q.en_lo) >> irq_vec[2:0])})
      else $error("level does not match enable pair");

   chk_level_nonzero: assert property (
      @(posedge clk) disable iff (sys_rst)
      irq_req |-> irq_level != 2'h0)
      else $error("disabled source was forwarded");

   chk_top_level_wins: assert property (
      @(posedge clk) disable iff (sys_rst)
      st_q.gie && (|(st_q.g0_pend & st_q.en_hi & st_q.en_lo)) |=>
         irq_level == 2'h3)
      else $error("highest level not chosen");

   chk_sw_clear: assert property (
      @(posedge clk) disable iff (sys_rst)
      wr_now && idx == prq_pkg::IDX_PC_PEND && !wb_dat_i[0] &&
      !pin_rise[0] && !(irq_ack && st_q.req) |=> !st_q.pc_pend[0])
      else $error("writing zero did not clear pending bit");

   chk_pend_upper_zero: assert property (
      @(posedge clk) disable iff (sys_rst)
      wb_ack_o && !wb_we_i && idx == prq_pkg::IDX_PC_PEND |->
         wb_dat_o[7:4] == 4'h0)
      else $error("reserved pending bits read non zero");

   chk_wb_ack_pulse: assert property (@(posedge clk) disable iff (sys_rst)
      bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("wishbone ack timing wrong");

   chk_ack_clears_pc: assert property (
      @(posedge clk) disable iff (sys_rst)
      irq_ack && irq_req && irq_vec >= 4'h8 && !pin_rise[irq_vec[1:0]] |=>
         1'(st_q.pc_pend >> $past(irq_vec[1:0])) == 1'b0)
      else $error("accepted port c source still pending");

   chk_ack_clears_g0: assert property (
      @(posedge clk) disable iff (sys_rst)
      irq_ack && irq_req && irq_vec < 4'h8 &&
      !request_group_zero[irq_vec[2:0]] |=>
         1'(st_q.g0_pend >> $past(irq_vec[2:0])) == 1'b0)
      else $error("accepted group zero source still pending");

   chk_req_needs_pend: assert property (
      @(posedge clk) disable iff (sys_rst)
      irq_req |-> $past(|st_q.pc_pend || |st_q.g0_pend))
      else $error("vectored request with nothing pending");

   chk_vec_in_range: assert property (
      @(posedge clk) disable iff (sys_rst)
      irq_req |-> irq_vec < 4'hC)
      else $error("vector names no source");

   chk_pc_level_fixed: assert property (
      @(posedge clk) disable iff (sys_rst)
      irq_req && irq_vec >= 4'h8 |-> irq_level == prq_pkg::LVL_PORT_C)
      else $error("port c source has wrong level");

   chk_gp_write_clear: assert property (
      @(posedge clk) disable iff (sys_rst)
      wr_now && idx == prq_pkg::IDX_G0_PEND && !wb_dat_i[0] &&
      !request_group_zero[0] && !(irq_ack && st_q.req) |=>
         !st_q.g0_pend[0])
      else $error("writing zero did not clear group zero bit");

   chk_en_hi_write: assert property (
      @(posedge clk) disable iff (sys_rst)
      wr_now && idx == prq_pkg::IDX_G0_EN_HI |=>
         st_q.en_hi == $past(wb_dat_i[7:0]))
      else $error("enable high write lost");

   chk_en_lo_write: assert property (
      @(posedge clk) disable iff (sys_rst)
      wr_now && idx == prq_pkg::IDX_G0_EN_LO |=>
         st_q.en_lo == $past(wb_dat_i[7:0]))
      else $error("enable low write lost");

   chk_poll_stat_set: assert property (
      @(posedge clk) disable iff (sys_rst)
      !st_q.gie && (|st_q.pc_pend) |=>
         st_q.ev_stat[prq_pkg::EV_POLL_PEND])
      else $error("polled pending status not set");

   chk_pc_stat_set: assert property (
      @(posedge clk) disable iff (sys_rst)
      |pin_rise |=> st_q.ev_stat[prq_pkg::EV_PC_REQ])
      else $error("port c status bit not set");

   chk_g0_stat_set: assert property (
      @(posedge clk) disable iff (sys_rst)
      |request_group_zero |=> st_q.ev_stat[prq_pkg::EV_G0_REQ])
      else $error("group zero status bit not set");

   chk_stat_read_clr: assert property (
      @(posedge clk) disable iff (sys_rst)
      rd_now && idx == prq_pkg::IDX_INT_STAT && st_q.gie &&
      !(|pin_rise) && !(|request_group_zero) |=>
         (st_q.ev_stat & $past(wb_dat_o[2:0])) == 3'h0)
      else $error("status read did not clear reported bits");

   chk_unmapped_zero: assert property (
      @(posedge clk) disable iff (sys_rst)
      bus_req && wb_ack_o && !wb_we_i &&
      (idx < prq_pkg::IDX_G0_PEND || idx > prq_pkg::IDX_VEC_STAT ||
       (idx > prq_pkg::IDX_G0_EN_LO && idx < prq_pkg::IDX_PC_PEND)) |->
         wb_dat_o == 32'h0000_0000)
      else $error("unmapped read returned data");
endmodule // prq_ctrl

/* verif/prq_core_model.sv */
// core model that takes vectored requests and accepts them
`timescale 1ns/1ps
module prq_core_model (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [3:0] dly,
   input  wire logic       irq_req,
   input  wire logic [1:0] irq_level,
   input  wire logic [3:0] irq_vec,
   output logic            irq_ack
);
   logic [5:0] taken_q[$];
   int         wait_q;
   int         hold_q;
   always @(posedge clk) begin
      irq_ack <= 1'b0;
      // log the vector standing at the edge the accept is seen
      if (!sys_rst && irq_ack && irq_req === 1'b1) begin
         taken_q.push_back({irq_level, irq_vec});
      end
      if (sys_rst) begin
         wait_q <= 0;
         hold_q <= 0;
      end else if (hold_q != 0) begin
         hold_q <= hold_q - 1;
      end else if (irq_req === 1'b1) begin
         if (wait_q < dly) begin
            wait_q <= wait_q + 1;
         end else begin
            irq_ack <= 1'b1;
            wait_q <= 0;
            // vector moves two cycles after an accept
            hold_q <= 3;
         end
      end
   end
endmodule // prq_core_model

/* verif/pending_request_priority_tb.sv */
// self-checking bench for the pending request priority block
`timescale 1ns/1ps
module pending_request_priority_tb;
   localparam logic [11:0] PC = prq_pkg::IDX_PC_PEND;
   localparam logic [11:0] GP = prq_pkg::IDX_G0_PEND;
   localparam logic [11:0] ST = prq_pkg::IDX_INT_STAT;
   localparam logic [11:0] CT = prq_pkg::IDX_CTRL;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0]  sel = 4'hF;
   logic [15:0] adr = 16'h0000;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic        ack, irq_ack, irq_req, irq_o;
   logic [1:0]  lvl;
   logic [3:0]  vec, pin = 4'h0, dly = 4'h0;
   logic [7:0]  g0 = 8'h00, q, e;
   logic [31:0] rnd = 32'hC1BC4CF9;
   logic [5:0]  exp_q[$];
   int          miscompares = 0, check_count = 0, cyc_n = 0, b, c;
   always #5 clk = ~clk;
   prq_ctrl dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .port_c_pin_request(pin), .request_group_zero(g0),
      .irq_ack(irq_ack), .irq_req(irq_req), .irq_level(lvl),
      .irq_vec(vec), .irq_o(irq_o));
   prq_core_model core (.clk(clk), .sys_rst(sys_rst), .dly(dly),
      .irq_req(irq_req), .irq_level(lvl), .irq_vec(vec),
      .irq_ack(irq_ack));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [11:0] i,
                      input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {2'b00, i, 2'b00};
      wdat <= {24'h0, d};
      // wait for the answer; the cycle watchdog ends a hang
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] i, input logic [7:0] e,
                     input string n);
      bus(1'b0, i, 8'h00);
      chk(n, e, q);
   endtask
   task automatic pin_rise(input int p);
      @(posedge clk);
      pin[p] <= 1'b1;
      repeat (6) @(posedge clk);
      pin[p] <= 1'b0;
   endtask
   task automatic pulse(input logic [7:0] m);
      @(posedge clk);
      g0 <= m;
      @(posedge clk);
      g0 <= 8'h00;
   endtask
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n > 20000) begin
         miscompares++;
         summarize();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(PC, 8'h00, "pc_reset");
      rd(12'h123, 8'h00, "unmapped");
      e = 8'h00;
      for (int p = 0; p < 4; p++) begin
         pin_rise(p);
         e[p] = 1'b1;
         chk("irq_req_polled", 8'h00, {7'h0, irq_req});
         rd(PC, e, "pc_pend");
      end
      sel <= 4'h0;
      bus(1'b1, PC, 8'h00);
      sel <= 4'hF;
      rd(PC, 8'h0F, "sel_ignored");
      bus(1'b1, PC, 8'h0A);
      rd(PC, 8'h0A, "pc_clear");
      bus(1'b1, PC, 8'h00);
      rd(ST, 8'h05, "stat_poll");
      rd(ST, 8'h00, "stat_clear");
      for (c = 0; c < 4; c++) begin
         rnd = lfsr(rnd);
         b = int'(rnd[2:0]);
         dly <= rnd[7:4];
         bus(1'b1, prq_pkg::IDX_G0_EN_HI, 8'(c / 2) << b);
         bus(1'b1, prq_pkg::IDX_G0_EN_LO, 8'(c % 2) << b);
         bus(1'b1, CT, 8'h01);
         pulse(8'h01 << b);
         repeat (25) @(posedge clk);
         chk("taken", 8'(c != 0), 8'(core.taken_q.size()));
         if (c == 0) rd(GP, 8'h01 << b, "g0_off_pend");
         else begin
            e = {2'b00, 2'(c), 4'(b)};
            chk("lvl_vec", e, {2'b00, core.taken_q.pop_front()});
         end
         bus(1'b1, GP, 8'h00);
         bus(1'b1, CT, 8'h00);
      end
      bus(1'b1, prq_pkg::IDX_G0_EN_HI, 8'h80);
      bus(1'b1, prq_pkg::IDX_G0_EN_LO, 8'h81);
      pulse(8'h81);
      repeat (4) @(posedge clk);
      chk("irq_req_off", 8'h00, {7'h0, irq_req});
      rd(prq_pkg::IDX_VEC_STAT, 8'h67, "vec_polled");
      rd(prq_pkg::IDX_G0_EN_HI, 8'h80, "en_hi_rb");
      rd(prq_pkg::IDX_G0_EN_LO, 8'h81, "en_lo_rb");
      exp_q = '{6'h37, 6'h10};
      bus(1'b1, CT, 8'h01);
      repeat (60) @(posedge clk);
      chk("taken2", 8'h02, 8'(core.taken_q.size()));
      foreach (exp_q[k]) chk("order", {2'b00, exp_q[k]},
                             {2'b00, core.taken_q[k]});
      core.taken_q.delete();
      bus(1'b0, ST, 8'h00);
      bus(1'b1, prq_pkg::IDX_INT_MASK, 8'h01);
      pin_rise(1);
      repeat (20) @(posedge clk);
      chk("irq_o_set", 8'h01, {7'h0, irq_o});
      chk("pc_taken", 8'h19, {2'b00, core.taken_q.pop_front()});
      rd(ST, 8'h01, "stat_pc");
      @(posedge clk);
      chk("irq_o_clr", 8'h00, {7'h0, irq_o});
      bus(1'b1, prq_pkg::IDX_INT_MASK, 8'h00);
      pin_rise(2);
      repeat (20) @(posedge clk);
      chk("irq_o_mask", 8'h00, {7'h0, irq_o});
      rd(ST, 8'h01, "stat_masked");
      summarize();
   end
endmodule // pending_request_priority_tb
